// ==== shared/socb_pkg.sv ====
// Constants, register map and state types of the signal output crossbar
// What this block does
// - Each output follows its own selected source
// - Selector word position picks the output line
// - Positions 0..4 drive front differential outputs
// - Positions 5 and 6 drive NIM outputs
// - 7..14 rear outputs, 15 trigger, 16 sync
// - Codes 0,1 constants; 2..4 backplane lines
// - Codes 5..9 front, 10..17 rear inputs
// - 18 pulser, 19 busy, 20..27 firmware triggers
// - Pulser period held in 4 ns ticks
package socb_pkg;
	// Register port geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int SEL_W = 5;
	// Crossbar size
	localparam int NUM_OUT = 17;
	localparam int NUM_SOURCES = 28;
	// Byte addresses: selector array, then the pulser period word
	localparam logic [ADDR_W-1:0] SELECTOR_BASE = 16'h0000;
	localparam logic [ADDR_W-1:0] SELECTOR_END = 16'h0044;
	localparam logic [ADDR_W-1:0] PULSER_CYCLE_LENGTH_OFF = 16'h0080;
	// Reset values
	localparam logic [SEL_W-1:0] SELECTOR_RESET = 5'h00;
	localparam logic [DATA_W-1:0] PULSER_RESET = 32'h00000000;
	// Pulser period unit
	localparam int PULSER_TICK_NS = 4;
	// Output line positions in the selector array
	localparam int FRONT_DIFF_OUT_ZERO = 0;
	localparam int FRONT_DIFF_OUT_N = 5;
	localparam int FRONT_NIM_OUT_ZERO = 5;
	localparam int FRONT_NIM_OUT_N = 2;
	localparam int REAR_DIFF_OUT_ZERO = 7;
	localparam int REAR_DIFF_OUT_N = 8;
	localparam int INTERNAL_TRIGGER_NET = 15;
	localparam int INTERNAL_SYNC_NET = 16;
	// Source codes
	localparam logic [SEL_W-1:0] CONST_LOW_CODE = 5'h00;
	localparam logic [SEL_W-1:0] CONST_HIGH_CODE = 5'h01;
	localparam logic [SEL_W-1:0] BACKPLANE_SYNC_CODE = 5'h02;
	localparam logic [SEL_W-1:0] BACKPLANE_TRIG_ONE_CODE = 5'h03;
	localparam logic [SEL_W-1:0] BACKPLANE_TRIG_TWO_CODE = 5'h04;
	localparam logic [SEL_W-1:0] FRONT_DIFF_IN_CODE = 5'h05;
	localparam logic [SEL_W-1:0] REAR_DIFF_IN_CODE = 5'h0A;
	localparam logic [SEL_W-1:0] PULSER_OUT_CODE = 5'h12;
	localparam logic [SEL_W-1:0] BUILDER_BUSY_CODE = 5'h13;
	localparam logic [SEL_W-1:0] FIRMWARE_TRIGGER_CODE = 5'h14;
	localparam logic [SEL_W-1:0] LAST_CODE = 5'h1B;
	// State of one crossbar cell
	typedef struct packed {
		logic [SEL_W-1:0] source_code_field;
		logic line;
	} socb_cell_state_t;
	// State of the top: register port answer and pulser period
	typedef struct packed {
		logic [DATA_W-1:0] pulser_cycle_length;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
	} socb_top_state_t;
endpackage

// ==== logic/socb_cell.sv ====
// One crossbar cell: a selector word and its registered output line
`timescale 1ns/1ps
module socb_cell
(
	input wire logic clk, // Logic clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic wr_en, // Write strobe for this selector word
	input wire logic [socb_pkg::SEL_W-1:0] wdata, // New source code
	input wire logic [socb_pkg::NUM_SOURCES-1:0] sources, // Source lines
	output logic [socb_pkg::SEL_W-1:0] source_code_field, // Selector
	output logic line // Routed output line
);
	socb_pkg::socb_cell_state_t state; // Registered state
	socb_pkg::socb_cell_state_t next_state; // Next value

	// Selector update and routing from the stored code
	always_comb
	begin
		next_state = state;
		if (wr_en)
		begin
			next_state.source_code_field = wdata;
		end
		// Unused codes drive low so a bad write cannot leave a line floating
		if (state.source_code_field <= socb_pkg::LAST_CODE)
		begin
			next_state.line = sources[state.source_code_field];
		end
		else
		begin
			next_state.line = 1'b0;
		end
	end

	// State register; reset gives code zero, a constant low line
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= '{socb_pkg::SELECTOR_RESET, 1'b0};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign source_code_field = state.source_code_field;
	assign line = state.line;

	// Checks on routing
	sel_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_en |=> source_code_field == $past(wdata))
		else $error("selector not stored");
	const_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		(source_code_field == socb_pkg::CONST_HIGH_CODE) |=> line)
		else $error("constant high code not high");
	unused_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		(source_code_field > socb_pkg::LAST_CODE) |=> !line)
		else $error("unused code not low");
	route_front_a: assert property (@(posedge clk) disable iff (!rst_n)
		(source_code_field == socb_pkg::FRONT_DIFF_IN_CODE)
		|=> line == $past(sources[5]))
		else $error("front input zero not routed");
	route_pulser_a: assert property (@(posedge clk) disable iff (!rst_n)
		(source_code_field == socb_pkg::PULSER_OUT_CODE)
		|=> line == $past(sources[18]))
		else $error("pulser not routed");
	route_sync_a: assert property (@(posedge clk) disable iff (!rst_n)
		(source_code_field == socb_pkg::BACKPLANE_SYNC_CODE)
		|=> line == $past(sources[2]))
		else $error("backplane sync not routed");
	reset_clear_a: assert property (@(posedge clk)
		$rose(rst_n) |-> (source_code_field == 5'h00) && !line)
		else $error("cell not cleared by reset");
	high_seen_c: cover property (@(posedge clk) disable iff (!rst_n)
		(source_code_field == socb_pkg::CONST_HIGH_CODE) ##1 line);
endmodule // socb_cell

// ==== logic/socb_crossbar.sv ====
// Top of the signal output crossbar with its register port
`timescale 1ns/1ps
module socb_crossbar
(
	input wire logic REF_CLK, // Logic clock, 40 MHz
	input wire logic RESETN, // Asynchronous reset, active low
	input wire logic [socb_pkg::ADDR_W-1:0] REG_ADDR, // Byte address
	input wire logic REG_WR, // Write strobe, one cycle
	input wire logic [socb_pkg::DATA_W-1:0] REG_WDATA, // Write data
	input wire logic REG_RD, // Read strobe, one cycle
	output logic [socb_pkg::DATA_W-1:0] REG_RDATA, // Read data
	output logic REG_RVALID, // Read data valid, one cycle
	input wire logic BP_SYNC, // Backplane sync line
	input wire logic BP_TRIG_ONE, // Backplane trigger one
	input wire logic BP_TRIG_TWO, // Backplane trigger two
	input wire logic [4:0] FRONT_DIFF_IN, // Front differential inputs
	input wire logic [7:0] REAR_DIFF_IN, // Rear differential inputs
	input wire logic PULSER_IN, // Pulser output from pulser logic
	input wire logic BUILDER_BUSY, // Event builder busy
	input wire logic [7:0] FIRMWARE_TRIGGER, // Firmware trigger signals
	output logic [4:0] FRONT_DIFF_OUT, // Front differential outputs
	output logic [1:0] FRONT_NIM_OUT, // Front NIM outputs
	output logic [7:0] REAR_DIFF_OUT, // Rear differential outputs
	output logic INTERNAL_TRIGGER, // Internal trigger net
	output logic INTERNAL_SYNC, // Internal sync net
	output logic [socb_pkg::DATA_W-1:0] PULSER_CYCLE_LENGTH // Period
);
	socb_pkg::socb_top_state_t state; // Registered state
	socb_pkg::socb_top_state_t next_state; // Next value
	logic [socb_pkg::NUM_SOURCES-1:0] sources; // Source bus, code order
	logic [socb_pkg::NUM_OUT-1:0] lines; // Cell outputs
	logic [socb_pkg::SEL_W-1:0] codes [socb_pkg::NUM_OUT]; // Readback
	logic sel_hit; // Address falls in the selector array
	logic [4:0] sel_index; // Word position within the array

	// Sources in code order: bit n is the line that code n names
	assign sources = {FIRMWARE_TRIGGER, BUILDER_BUSY, PULSER_IN,
		REAR_DIFF_IN, FRONT_DIFF_IN, BP_TRIG_TWO, BP_TRIG_ONE, BP_SYNC,
		1'b1, 1'b0};

	// Selector decode: word aligned and inside the array
	assign sel_hit = (REG_ADDR[1:0] == 2'h0)
		&& (REG_ADDR >= socb_pkg::SELECTOR_BASE)
		&& (REG_ADDR < socb_pkg::SELECTOR_END);
	assign sel_index = REG_ADDR[6:2];

	// One cell per output; its array position fixes which line it drives
	generate
		for (genvar i = 0; i < socb_pkg::NUM_OUT; i++)
		begin : g_cell
			socb_cell u_cell
			(
				.clk(REF_CLK),
				.rst_n(RESETN),
				.wr_en(REG_WR && sel_hit && (sel_index == 5'(i))),
				.wdata(REG_WDATA[socb_pkg::SEL_W-1:0]),
				.sources(sources),
				.source_code_field(codes[i]),
				.line(lines[i])
			);
		end
	endgenerate

	// Register writes and reads; unmapped reads return zero
	always_comb
	begin
		next_state = state;
		next_state.rvalid = REG_RD;
		next_state.rdata = 32'h00000000;
		if (REG_WR && (REG_ADDR == socb_pkg::PULSER_CYCLE_LENGTH_OFF))
		begin
			next_state.pulser_cycle_length = REG_WDATA;
		end
		if (REG_RD && sel_hit)
		begin
			// Reserved bits above the code read as zero
			next_state.rdata = {27'h0000000, codes[sel_index]};
		end
		else if (REG_RD
			&& (REG_ADDR == socb_pkg::PULSER_CYCLE_LENGTH_OFF))
		begin
			next_state.rdata = state.pulser_cycle_length;
		end
	end

	// State register
	always_ff @(posedge REF_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state <= '{socb_pkg::PULSER_RESET, 32'h00000000,
				1'b0};
		end
		else
		begin
			state <= next_state;
		end
	end

	// Outputs come straight from cell or top flip-flops
	assign REG_RDATA = state.rdata;
	assign REG_RVALID = state.rvalid;
	assign PULSER_CYCLE_LENGTH = state.pulser_cycle_length;
	assign FRONT_DIFF_OUT = lines[socb_pkg::FRONT_DIFF_OUT_ZERO +:
		socb_pkg::FRONT_DIFF_OUT_N];
	assign FRONT_NIM_OUT = lines[socb_pkg::FRONT_NIM_OUT_ZERO +:
		socb_pkg::FRONT_NIM_OUT_N];
	assign REAR_DIFF_OUT = lines[socb_pkg::REAR_DIFF_OUT_ZERO +:
		socb_pkg::REAR_DIFF_OUT_N];
	assign INTERNAL_TRIGGER = lines[socb_pkg::INTERNAL_TRIGGER_NET];
	assign INTERNAL_SYNC = lines[socb_pkg::INTERNAL_SYNC_NET];

	// Checks on the register port and the line mapping
	period_write_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_ADDR == 16'h0080)
		|=> PULSER_CYCLE_LENGTH == $past(REG_WDATA))
		else $error("pulser period not stored");
	read_answer_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_RD |=> REG_RVALID ##1 !REG_RVALID || $past(REG_RD))
		else $error("read answer timing wrong");
	front_map_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_ADDR == 16'h0000) && (REG_WDATA[4:0] == 5'h01)
		|-> ##2 FRONT_DIFF_OUT[0])
		else $error("position 0 not front output 0");
	nim_map_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_ADDR == 16'h0018) && (REG_WDATA[4:0] == 5'h01)
		|-> ##2 FRONT_NIM_OUT[1])
		else $error("position 6 not NIM output 1");
	rear_map_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_ADDR == 16'h001C) && (REG_WDATA[4:0] == 5'h01)
		|-> ##2 REAR_DIFF_OUT[0])
		else $error("position 7 not rear output 0");
	sync_map_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_ADDR == 16'h0040) && (REG_WDATA[4:0] == 5'h01)
		|-> ##2 INTERNAL_SYNC)
		else $error("position 16 not sync net");
	reset_low_a: assert property (@(posedge REF_CLK)
		$rose(RESETN) |-> (PULSER_CYCLE_LENGTH == 32'h00000000)
		&& (FRONT_DIFF_OUT == 5'h00) && !INTERNAL_TRIGGER)
		else $error("outputs not low after reset");
	trig_route_c: cover property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_ADDR == 16'h003C) ##2 INTERNAL_TRIGGER);
	period_read_c: cover property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_RD && (REG_ADDR == 16'h0080) ##1 REG_RVALID);
	busy_route_c: cover property (@(posedge REF_CLK) disable iff (!RESETN)
		REG_WR && (REG_WDATA[4:0] == 5'h13) ##2 BUILDER_BUSY);
endmodule // socb_crossbar

// ==== bench/socb_lines_model.sv ====
// Bench model of the source lines that feed the crossbar
`timescale 1ns/1ps
module socb_lines_model
(
	input wire logic [27:0] lines, // Wanted level, bit n feeds code n
	output logic bp_sync, // Backplane sync
	output logic bp_trig_one, // Backplane trigger one
	output logic bp_trig_two, // Backplane trigger two
	output logic [4:0] front_in, // Front differential inputs
	output logic [7:0] rear_in, // Rear differential inputs
	output logic pulser, // Pulser output
	output logic busy, // Event builder busy
	output logic [7:0] fw_trig // Firmware triggers
);
	// Codes 0 and 1 are constants inside the block, so bits 0..1 go nowhere
	assign {fw_trig, busy, pulser, rear_in, front_in, bp_trig_two,
		bp_trig_one, bp_sync} = lines[27:2];
endmodule // socb_lines_model

// ==== bench/socb_crossbar_tb.sv ====
// Self-checking bench of the signal output crossbar
`timescale 1ns/1ps
module socb_crossbar_tb;
	// One row: selector position, code, line with source high and low
	typedef struct {int pos; logic [4:0] code; logic hi; logic lo;} socb_row_t;
	socb_row_t rows[32]; // One row per code
	logic ref_clk; // Logic clock
	logic resetn; // Reset, active low
	logic [socb_pkg::ADDR_W-1:0] reg_addr; // Register address
	logic reg_wr; // Write strobe
	logic reg_rd; // Read strobe
	logic [socb_pkg::DATA_W-1:0] reg_wdata; // Write data
	logic [socb_pkg::DATA_W-1:0] reg_rdata; // Read data
	logic reg_rvalid; // Read answer
	logic [socb_pkg::DATA_W-1:0] period; // Exported period
	logic [socb_pkg::DATA_W-1:0] d; // Last read word
	logic [27:0] lines; // Source levels
	logic sy, t1, t2, pu, bu; // Single source lines
	logic [4:0] fi; // Front inputs
	logic [7:0] ri, fw; // Rear inputs, firmware triggers
	logic [4:0] fo; // Front outputs
	logic [1:0] no; // NIM outputs
	logic [7:0] ro; // Rear outputs
	logic it, is; // Internal trigger and sync
	logic [16:0] outs; // Outputs in selector order
	int errors;
	int num_checks;
	assign outs = {is, it, ro, no, fo};
	socb_lines_model socb_lines_model_i (.lines(lines), .bp_sync(sy),
		.bp_trig_one(t1), .bp_trig_two(t2), .front_in(fi), .rear_in(ri),
		.pulser(pu), .busy(bu), .fw_trig(fw));
	socb_crossbar socb_crossbar_i (.REF_CLK(ref_clk), .RESETN(resetn),
		.REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
		.BP_SYNC(sy), .BP_TRIG_ONE(t1), .BP_TRIG_TWO(t2),
		.FRONT_DIFF_IN(fi), .REAR_DIFF_IN(ri), .PULSER_IN(pu),
		.BUILDER_BUSY(bu), .FIRMWARE_TRIGGER(fw), .FRONT_DIFF_OUT(fo),
		.FRONT_NIM_OUT(no), .REAR_DIFF_OUT(ro), .INTERNAL_TRIGGER(it),
		.INTERNAL_SYNC(is), .PULSER_CYCLE_LENGTH(period));
	// Word comparison
	task automatic chk_word(string name, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask
	// Single line comparison
	task automatic chk_line(string name, logic e, logic g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %b seen %b", name, e, g);
		end
	endtask
	// Write one word, strobe held for exactly one edge
	task automatic wr(logic [15:0] a, logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read one word; the answer is registered on the taking edge and checked 1 ns after it
	task automatic rd(logic [15:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk_line("read valid", 1'b1, reg_rvalid);
		d = reg_rdata;
	endtask
	// Verdict and end of run
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Free-running 40 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// Watchdog, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		results();
	end
	// Main sequence
	initial
	begin
		{resetn, reg_addr, reg_wr, reg_rd, reg_wdata, lines} = '0;
		errors = 0;
		num_checks = 0;
		for (int i = 0; i < 32; i++)
			rows[i] = '{i % 17, 5'(i), (i >= 1 && i <= 27), (i == 1)};
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		#1;
		chk_word("outputs after reset", 32'h0, {15'h0, outs});
		rd(16'h0040);
		chk_word("selector reset", 32'h0, d);
		rd(16'h0080);
		chk_word("period reset", 32'h0, d);
		wr(16'h0080, 32'hA5A50F0F);
		rd(16'h0080);
		chk_word("period readback", 32'hA5A50F0F, d);
		chk_word("period port", 32'hA5A50F0F, period);
		rd(16'h0044);
		chk_word("unmapped read", 32'h0, d);
		// Upper write bits are set to prove they are dropped
		foreach (rows[i])
		begin
			wr(16'(rows[i].pos * 4), {27'h7FFFFFF, rows[i].code});
			lines <= rows[i].code > 5'h1B ? 28'hFFFFFFF : 28'h1 << rows[i].code;
			repeat (3) @(posedge ref_clk);
			#1;
			chk_line("line high", rows[i].hi, outs[rows[i].pos]);
			@(posedge ref_clk);
			lines <= ~lines;
			repeat (2) @(posedge ref_clk);
			#1;
			chk_line("line low", rows[i].lo, outs[rows[i].pos]);
			rd(16'(rows[i].pos * 4));
			chk_word("selector readback", {27'h0, rows[i].code}, d);
		end
		// Reset in mid-run clears every line and the period
		@(posedge ref_clk);
		lines <= 28'hFFFFFFF;
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk_word("outputs in reset", 32'h0, {15'h0, outs});
		chk_word("period in reset", 32'h0, period);
		results();
	end
endmodule // socb_crossbar_tb
